// [hdl/rsi_pkg.sv]
// constants and types for the reset state initializer
package rsi_pkg;

   // register offsets on the plain register port
   localparam logic [3:0] OFS_STATUS      = 4'h0;
   localparam logic [3:0] OFS_POWER_CTRL  = 4'h1;
   localparam logic [3:0] OFS_IRQ_CONTROL = 4'h2;
   localparam logic [3:0] OFS_PERIPH_IRQ  = 4'h3;
   localparam logic [3:0] OFS_OPTION      = 4'h4;
   localparam logic [3:0] OFS_PORT_A_DIR  = 4'h5;
   localparam logic [3:0] OFS_PORT_B_DIR  = 4'h6;
   localparam logic [3:0] OFS_EVT_STATUS  = 4'h7;
   localparam logic [3:0] OFS_EVT_MASK    = 4'h8;

   // status register fields
   localparam int STAT_TIMEOUT   = 4;
   localparam int STAT_POWERDOWN = 3;

   // power control fields
   localparam int PCTL_POWERON  = 1;
   localparam int PCTL_BROWNOUT = 0;

   // irq control fields
   localparam int IRQC_GIE = 7;

   // widths
   localparam int PERIPH_W = 5;
   localparam int EVT_W    = 6;

   // event status bit positions
   localparam int EVT_POR      = 0;
   localparam int EVT_BOR      = 1;
   localparam int EVT_PIN      = 2;
   localparam int EVT_WDT_RST  = 3;
   localparam int EVT_WDT_WAKE = 4;
   localparam int EVT_IRQ_WAKE = 5;

   // reset values
   localparam logic [7:0] STATUS_RST  = 8'h18;
   localparam logic [1:0] PCTL_RST    = 2'h0;
   localparam logic [7:0] ALL_ONES    = 8'hff;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;

   // reset or wake-up condition seen this cycle
   typedef enum logic [2:0]
   {
      COND_NONE,
      COND_POR,
      COND_BOR,
      COND_PIN_RUN,
      COND_PIN_SLEEP,
      COND_WDT_RST,
      COND_WDT_WAKE,
      COND_IRQ_WAKE
   } rsi_cond_t;

endpackage : rsi_pkg

// [hdl/rsi_sticky.sv]
// sticky event flags with read clear, mask and level interrupt
`timescale 1ns/1ns
`default_nettype none

module rsi_sticky #(
   parameter int N = 6
) (
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   input  wire logic [N-1:0] set_evt,
   input  wire logic         rd_clr,
   input  wire logic [N-1:0] mask,
   output logic      [N-1:0] flags,
   output logic              irq
);

   logic [N-1:0] flags_r;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         flags_r <= '0;
      else
         flags_r <= (flags_r & ~{N{rd_clr}}) | set_evt;
   end

   assign flags = flags_r;
   assign irq   = |(flags_r & mask);

endmodule : rsi_sticky

`default_nettype wire

// [hdl/rsi_top.sv]
// reset and wake-up state loader for the special registers
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - power-on: pc zero, status 0001 1xxx, clear power-on flag
// - pin reset running: pc zero, clear upper status bits, rest kept
// - pin reset in sleep: pc zero, upper clear, timeout set, powerdown clear
// - interrupt wake: pc plus one, timeout set, powerdown clear
// - interrupt wake with global enable set: pc takes interrupt vector
// - resets set option and direction regs to ones, irq control 0000 000x
// - wake-ups keep registers; only the waking flag bits change
// - unimplemented bits read as zero
// - unchanged bits keep value; unknown bits need no init
// - timeout and powerdown take values chosen by the cause
// - power-on flag cleared only by power-on reset or a software write
// - timeout flag cleared when the watchdog expires with no power-on, brown-out or pin reset in the same cycle
// - global interrupt enable cleared by every reset
module rsi_top #(
   parameter int PC_W = 13
) (
   input  wire logic                mclk,
   input  wire logic                sys_rst,
   input  wire logic                por_evt,
   input  wire logic                bor_evt,
   input  wire logic                ext_reset_pin_evt,
   input  wire logic                watchdog_timer_evt,
   input  wire logic                irq_wake_evt,
   input  wire logic                sleeping,
   input  wire logic [PC_W-1:0]     cpu_pc,
   input  wire logic [7:0]          wake_irq_bits,
   input  wire logic [rsi_pkg::PERIPH_W-1:0] wake_periph_bits,
   input  wire logic [3:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic      [7:0]          reg_rdata,
   output logic                     pc_load,
   output logic      [PC_W-1:0]     pc_load_value,
   output logic      [7:0]          status_out,
   output logic      [1:0]          power_ctrl_status,
   output logic      [7:0]          irq_control,
   output logic      [rsi_pkg::PERIPH_W-1:0] periph_irq_flags,
   output logic      [7:0]          option_out,
   output logic      [7:0]          port_a_direction,
   output logic      [7:0]          port_b_direction,
   output logic                     irq
);

   rsi_pkg::rsi_cond_t           cond;
   logic                         is_reset, is_wake, sw_ok, pc_load_r;
   logic [7:0]                   status_r, irqc_r, rdata_r;
   logic [7:0]                   option_r, dir_a_r, dir_b_r;
   logic [1:0]                   pctl_r;
   logic [rsi_pkg::PERIPH_W-1:0] periph_r;
   logic [PC_W-1:0]              pc_val_r, pc_plus1, vector_pc;
   logic [rsi_pkg::EVT_W-1:0]    evt_set, evt_flags, evt_mask_r;

   // cause decode, the strongest reset wins when several coincide
   always_comb
   begin
      cond = rsi_pkg::COND_NONE;
      if (por_evt)
         cond = rsi_pkg::COND_POR;
      else if (bor_evt)
         cond = rsi_pkg::COND_BOR;
      else if (ext_reset_pin_evt)
         cond = sleeping ? rsi_pkg::COND_PIN_SLEEP : rsi_pkg::COND_PIN_RUN;
      else if (watchdog_timer_evt)
         cond = sleeping ? rsi_pkg::COND_WDT_WAKE : rsi_pkg::COND_WDT_RST;
      else if (irq_wake_evt && sleeping)
         cond = rsi_pkg::COND_IRQ_WAKE;
   end

   // condition classes; software writes, except to the event mask, lose to any condition
   assign is_reset = (cond != rsi_pkg::COND_NONE) && !is_wake;
   assign is_wake  = (cond == rsi_pkg::COND_WDT_WAKE) ||
                     (cond == rsi_pkg::COND_IRQ_WAKE);
   assign sw_ok    = reg_wr && (cond == rsi_pkg::COND_NONE);
   assign pc_plus1 = PC_W'(cpu_pc + 1'b1);
   assign vector_pc = rsi_pkg::IRQ_VECTOR[PC_W-1:0];

   // status register: upper bits, timeout, powerdown, low flags
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         status_r <= rsi_pkg::STATUS_RST;
      else
         case (cond)
            rsi_pkg::COND_POR,
            rsi_pkg::COND_BOR:
               status_r <= {5'h03, status_r[2:0]};
            rsi_pkg::COND_PIN_RUN:
               status_r <= {3'h0, status_r[4:0]};
            rsi_pkg::COND_PIN_SLEEP:
               status_r <= {5'h02, status_r[2:0]};
            rsi_pkg::COND_WDT_RST:
               status_r <= {5'h01, status_r[2:0]};
            rsi_pkg::COND_WDT_WAKE:
               status_r <= {status_r[7:5], 2'h0, status_r[2:0]};
            rsi_pkg::COND_IRQ_WAKE:
               status_r <= {status_r[7:5], 2'h2, status_r[2:0]};
            default:
               if (sw_ok && reg_addr == rsi_pkg::OFS_STATUS)
                  status_r <= reg_wdata;
         endcase
   end

   // power control flags: power-on and brown-out
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         pctl_r <= rsi_pkg::PCTL_RST;
      else if (cond == rsi_pkg::COND_POR)
         pctl_r[rsi_pkg::PCTL_POWERON] <= 1'b0;
      else if (cond == rsi_pkg::COND_BOR)
         pctl_r[rsi_pkg::PCTL_BROWNOUT] <= 1'b0;
      else if (sw_ok && reg_addr == rsi_pkg::OFS_POWER_CTRL)
         pctl_r <= reg_wdata[1:0];
   end

   // program counter load request and value
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pc_load_r <= 1'b0;
         pc_val_r  <= '0;
      end
      else
      begin
         pc_load_r <= is_reset || is_wake;
         if (is_reset)
            pc_val_r <= '0;
         else if (cond == rsi_pkg::COND_IRQ_WAKE &&
                  irqc_r[rsi_pkg::IRQC_GIE])
            pc_val_r <= vector_pc;
         else if (is_wake)
            pc_val_r <= pc_plus1;
      end
   end

   // irq control: resets clear all but bit 0, wakes or in the cause
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         irqc_r <= rsi_pkg::ZERO_BYTE;
      else if (is_reset)
         irqc_r <= {7'h00, irqc_r[0]};
      else if (is_wake)
         irqc_r <= irqc_r | wake_irq_bits;
      else if (sw_ok && reg_addr == rsi_pkg::OFS_IRQ_CONTROL)
         irqc_r <= reg_wdata;
   end

   // peripheral irq flags
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         periph_r <= '0;
      else if (is_reset)
         periph_r <= '0;
      else if (is_wake)
         periph_r <= periph_r | wake_periph_bits;
      else if (sw_ok && reg_addr == rsi_pkg::OFS_PERIPH_IRQ)
         periph_r <= reg_wdata[rsi_pkg::PERIPH_W-1:0];
   end

   // timer option and port directions go to all ones on reset
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         option_r <= rsi_pkg::ALL_ONES;
         dir_a_r  <= rsi_pkg::ALL_ONES;
         dir_b_r  <= rsi_pkg::ALL_ONES;
      end
      else if (is_reset)
      begin
         option_r <= rsi_pkg::ALL_ONES;
         dir_a_r  <= rsi_pkg::ALL_ONES;
         dir_b_r  <= rsi_pkg::ALL_ONES;
      end
      else if (sw_ok)
      begin
         if (reg_addr == rsi_pkg::OFS_OPTION)
            option_r <= reg_wdata;
         if (reg_addr == rsi_pkg::OFS_PORT_A_DIR)
            dir_a_r <= reg_wdata;
         if (reg_addr == rsi_pkg::OFS_PORT_B_DIR)
            dir_b_r <= reg_wdata;
      end
   end

   // event mask register
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         evt_mask_r <= '0;
      else if (reg_wr && reg_addr == rsi_pkg::OFS_EVT_MASK)
         evt_mask_r <= reg_wdata[rsi_pkg::EVT_W-1:0];
   end

   // one event bit per cause
   always_comb
   begin
      evt_set = '0;
      evt_set[rsi_pkg::EVT_POR]      = (cond == rsi_pkg::COND_POR);
      evt_set[rsi_pkg::EVT_BOR]      = (cond == rsi_pkg::COND_BOR);
      evt_set[rsi_pkg::EVT_PIN]      = (cond == rsi_pkg::COND_PIN_RUN) ||
                                       (cond == rsi_pkg::COND_PIN_SLEEP);
      evt_set[rsi_pkg::EVT_WDT_RST]  = (cond == rsi_pkg::COND_WDT_RST);
      evt_set[rsi_pkg::EVT_WDT_WAKE] = (cond == rsi_pkg::COND_WDT_WAKE);
      evt_set[rsi_pkg::EVT_IRQ_WAKE] = (cond == rsi_pkg::COND_IRQ_WAKE);
   end

   rsi_sticky #(
      .N       (rsi_pkg::EVT_W)
   ) u_evt (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .set_evt (evt_set),
      .rd_clr  (reg_rd && reg_addr == rsi_pkg::OFS_EVT_STATUS),
      .mask    (evt_mask_r),
      .flags   (evt_flags),
      .irq     (irq)
   );

   // read port, narrow registers padded with zeros
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         rdata_r <= rsi_pkg::ZERO_BYTE;
      else if (reg_rd)
         case (reg_addr)
            rsi_pkg::OFS_STATUS:      rdata_r <= status_r;
            rsi_pkg::OFS_POWER_CTRL:  rdata_r <= {6'h00, pctl_r};
            rsi_pkg::OFS_IRQ_CONTROL: rdata_r <= irqc_r;
            rsi_pkg::OFS_PERIPH_IRQ:  rdata_r <= {3'h0, periph_r};
            rsi_pkg::OFS_OPTION:      rdata_r <= option_r;
            rsi_pkg::OFS_PORT_A_DIR:  rdata_r <= dir_a_r;
            rsi_pkg::OFS_PORT_B_DIR:  rdata_r <= dir_b_r;
            rsi_pkg::OFS_EVT_STATUS:  rdata_r <= {2'h0, evt_flags};
            rsi_pkg::OFS_EVT_MASK:    rdata_r <= {2'h0, evt_mask_r};
            default:                  rdata_r <= rsi_pkg::ZERO_BYTE;
         endcase
   end

   // outputs straight from the registers
   assign reg_rdata         = rdata_r;
   assign pc_load           = pc_load_r;
   assign pc_load_value     = pc_val_r;
   assign status_out        = status_r;
   assign power_ctrl_status = pctl_r;
   assign irq_control       = irqc_r;
   assign periph_irq_flags  = periph_r;
   assign option_out        = option_r;
   assign port_a_direction  = dir_a_r;
   assign port_b_direction  = dir_b_r;

   // checks on the loaded values, all on the core clock and off in reset
   default clocking chk_cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   property p_por;
      cond == rsi_pkg::COND_POR |=> pc_load && pc_load_value == '0 &&
         status_r[7:3] == 5'h03 && !pctl_r[1];
   endproperty
   a_por: assert property (p_por) else $error("power-on load wrong");
   property p_pin_run;
      cond == rsi_pkg::COND_PIN_RUN |=> status_r[7:5] == 3'h0 &&
         status_r[4:0] == $past(status_r[4:0]) && pc_load_value == '0;
   endproperty
   a_pin_run: assert property (p_pin_run) else $error("pin reset wrong");
   property p_pin_sleep;
      cond == rsi_pkg::COND_PIN_SLEEP |=> status_r[7:3] == 5'h02 &&
         status_r[2:0] == $past(status_r[2:0]);
   endproperty
   a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep wrong");
   property p_irq_wake;
      cond == rsi_pkg::COND_IRQ_WAKE && !irqc_r[7] |=>
         pc_load_value == $past(pc_plus1) && status_r[4:3] == 2'h2;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("irq wake wrong");
   property p_vector;
      cond == rsi_pkg::COND_IRQ_WAKE && irqc_r[7] |=>
         pc_load && pc_load_value == vector_pc;
   endproperty
   a_vector: assert property (p_vector) else $error("vector not loaded");
   property p_dir_ones;
      is_reset |=> option_r == 8'hff && dir_a_r == 8'hff &&
         dir_b_r == 8'hff && irqc_r[7:1] == 7'h00 && periph_r == '0;
   endproperty
   a_dir_ones: assert property (p_dir_ones) else $error("reset regs wrong");
   property p_wake_keep;
      is_wake |=> $stable(option_r) && $stable(dir_a_r) && $stable(pctl_r)
         && irqc_r == ($past(irqc_r) | $past(wake_irq_bits));
   endproperty
   a_wake_keep: assert property (p_wake_keep) else $error("wake changed");
   property p_pad;
      reg_rd && reg_addr == rsi_pkg::OFS_POWER_CTRL |=> reg_rdata[7:2] == 6'h0;
   endproperty
   a_pad: assert property (p_pad) else $error("pad bits not zero");
   property p_pctl_kept;
      (is_reset || is_wake) && cond != rsi_pkg::COND_BOR &&
         cond != rsi_pkg::COND_POR |=> $stable(pctl_r);
   endproperty
   a_pctl_kept: assert property (p_pctl_kept) else $error("pctl moved");
   property p_poweron_only;
      $fell(pctl_r[1]) |-> $past(cond == rsi_pkg::COND_POR) || $past(sw_ok);
   endproperty
   a_poweron_only: assert property (p_poweron_only) else $error("pon flag");
   property p_wdt;
      watchdog_timer_evt && !por_evt && !bor_evt && !ext_reset_pin_evt
         |=> !status_r[4] && status_r[3] == !$past(sleeping);
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog flags wrong");
   property p_gie;
      is_reset |=> !irqc_r[7] ##1 1'b1;
   endproperty
   a_gie: assert property (p_gie) else $error("enable not cleared");
   property p_bor;
      cond == rsi_pkg::COND_BOR |=> !pctl_r[0] &&
         pctl_r[1] == $past(pctl_r[1]) && status_r[4:3] == 2'h3;
   endproperty
   a_bor: assert property (p_bor) else $error("brown-out wrong");

   c_por:   cover property (@(posedge mclk) cond == rsi_pkg::COND_POR);
   c_vec:   cover property (@(posedge mclk)
                            cond == rsi_pkg::COND_IRQ_WAKE && irqc_r[7]);
   c_wdtw:  cover property (@(posedge mclk) cond == rsi_pkg::COND_WDT_WAKE);
   c_irq:   cover property (@(posedge mclk) irq);

endmodule : rsi_top

`default_nettype wire

// [sim/rsi_cpu_model.sv]
// behavioural cpu program counter facing the state loader
`timescale 1ns/1ns
`default_nettype none

module rsi_cpu_model #(
   parameter int PC_W = 13
) (
   input  wire logic            mclk,
   input  wire logic            sys_rst,
   input  wire logic            pc_load,
   input  wire logic [PC_W-1:0] pc_load_value,
   input  wire logic            preset_en,
   input  wire logic [PC_W-1:0] preset_val,
   output logic      [PC_W-1:0] cpu_pc
);
   logic [PC_W-1:0] pc_r;

   // a load from the reset logic beats a preset from the bench
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         pc_r <= '0;
      else if (pc_load)
         pc_r <= pc_load_value;
      else if (preset_en)
         pc_r <= preset_val;
   end

   // current pc seen by the loader on a wake
   assign cpu_pc = pc_r;
endmodule : rsi_cpu_model
`default_nettype wire

// [sim/reset_state_initializer_bench.sv]
// self-checking bench for the reset state initializer
`timescale 1ns/1ns
`default_nettype none

module reset_state_initializer_bench;
   typedef struct packed
   {
      logic [2:0]  cause;
      logic        slp;
      logic        global_irq_enable;
      logic [12:0] pc;
      logic [7:0]  stat;
      logic [1:0]  pctl;
      logic        wake;
   } rsi_row_t;

   logic        mclk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [4:0]  cause_v = 5'h0;
   logic        sleeping = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        preset_en = 1'b0;
   logic [12:0] preset_val = 13'h0;
   logic [12:0] cpu_pc;
   logic [7:0]  reg_rdata;
   logic        pc_load;
   logic [12:0] pc_load_value;
   logic [7:0]  status_out;
   logic [1:0]  power_ctrl_status;
   logic [7:0]  irq_control;
   logic [4:0]  periph_irq_flags;
   logic [7:0]  option_out;
   logic [7:0]  port_a_direction;
   logic [7:0]  port_b_direction;
   logic        irq;
   int          errors = 0;
   int          samples_checked = 0;
   rsi_row_t    rows [8];
   rsi_row_t    r;
   logic [7:0]  pre;
   logic [7:0]  d;

   // 250 MHz core clock
   always #2 mclk = ~mclk;

   rsi_top #(.PC_W(13)) rsi_top_inst (
      .mclk              (mclk),
      .sys_rst           (sys_rst),
      .por_evt           (cause_v[0]),
      .bor_evt           (cause_v[1]),
      .ext_reset_pin_evt (cause_v[2]),
      .watchdog_timer_evt(cause_v[3]),
      .irq_wake_evt      (cause_v[4]),
      .sleeping          (sleeping),
      .cpu_pc            (cpu_pc),
      .wake_irq_bits     (8'h02),
      .wake_periph_bits  (5'h04),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .pc_load           (pc_load),
      .pc_load_value     (pc_load_value),
      .status_out        (status_out),
      .power_ctrl_status (power_ctrl_status),
      .irq_control       (irq_control),
      .periph_irq_flags  (periph_irq_flags),
      .option_out        (option_out),
      .port_a_direction  (port_a_direction),
      .port_b_direction  (port_b_direction),
      .irq               (irq)
   );

   rsi_cpu_model #(.PC_W(13)) rsi_cpu_model_inst (
      .mclk         (mclk),
      .sys_rst      (sys_rst),
      .pc_load      (pc_load),
      .pc_load_value(pc_load_value),
      .preset_en    (preset_en),
      .preset_val   (preset_val),
      .cpu_pc       (cpu_pc)
   );

   // compare one value and count it
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // one-cycle register read, data taken the cycle after
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   // one-cycle pulse on a cause input, settle after the taking edge
   task automatic fire(input int k);
      @(posedge mclk);
      cause_v <= 5'(1 << k);
      @(posedge mclk);
      cause_v <= 5'h0;
      #1;
   endtask : fire

   // prints the counts and the verdict, then ends the run
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   // cuts a hang short
   initial
   begin
      #100000;
      chk(16'h1, 16'h0);
      report_and_stop();
   end

   // main sequence
   initial
   begin
      rows[0] = '{3'd0, 1'b0, 1'b1, 13'h0, 8'h1d, 2'h1, 1'b0};
      rows[1] = '{3'd1, 1'b0, 1'b0, 13'h0, 8'h1d, 2'h2, 1'b0};
      rows[2] = '{3'd2, 1'b0, 1'b1, 13'h0, 8'h0d, 2'h3, 1'b0};
      rows[3] = '{3'd2, 1'b1, 1'b0, 13'h0, 8'h15, 2'h3, 1'b0};
      rows[4] = '{3'd3, 1'b0, 1'b1, 13'h0, 8'h0d, 2'h3, 1'b0};
      rows[5] = '{3'd3, 1'b1, 1'b0, 13'h124, 8'he5, 2'h3, 1'b1};
      rows[6] = '{3'd4, 1'b1, 1'b0, 13'h124, 8'hf5, 2'h3, 1'b1};
      rows[7] = '{3'd4, 1'b1, 1'b1, 13'h004, 8'hf5, 2'h3, 1'b1};
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(16'(status_out), 16'h18);
      chk(16'({power_ctrl_status, irq_control}), 16'h0);
      chk(16'({option_out, port_b_direction}), 16'hffff);
      chk(16'({pc_load, irq}), 16'h0);
      foreach (rows[i])
      begin
         r = rows[i];
         pre = r.global_irq_enable ? 8'h81 : 8'h01;
         wr(rsi_pkg::OFS_STATUS, 8'hed);
         wr(rsi_pkg::OFS_POWER_CTRL, 8'h03);
         wr(rsi_pkg::OFS_IRQ_CONTROL, pre);
         wr(rsi_pkg::OFS_PERIPH_IRQ, 8'h11);
         for (int a = 4; a < 7; a++)
            wr(4'(a), 8'h3c);
         @(posedge mclk);
         preset_en <= 1'b1;
         preset_val <= 13'h123;
         sleeping <= r.slp;
         @(posedge mclk);
         preset_en <= 1'b0;
         fire(int'(r.cause));
         chk(16'(pc_load), 16'h1);
         chk(16'(pc_load_value), 16'(r.pc));
         chk(16'(status_out), 16'(r.stat));
         chk(16'(power_ctrl_status), 16'(r.pctl));
         chk(16'(irq_control), 16'(r.wake ? pre | 8'h02 : 8'h01));
         chk(16'(periph_irq_flags), 16'(r.wake ? 5'h15 : 5'h0));
         chk(16'({option_out, port_a_direction}),
             r.wake ? 16'h3c3c : 16'hffff);
         chk(16'(port_b_direction), r.wake ? 16'h3c : 16'hff);
         @(posedge mclk);
         #1;
         chk(16'(pc_load), 16'h0);
      end
      // an interrupt wake while running is ignored
      @(posedge mclk);
      sleeping <= 1'b0;
      fire(4);
      chk(16'({pc_load, status_out}), 16'h0f5);
      rd(rsi_pkg::OFS_POWER_CTRL, d);
      chk(16'(d), 16'h03);
      rd(rsi_pkg::OFS_PERIPH_IRQ, d);
      chk(16'(d), 16'h15);
      rd(4'hf, d);
      chk(16'(d), 16'h00);
      // sticky events, mask and read clear
      chk(16'(irq), 16'h0);
      wr(rsi_pkg::OFS_EVT_MASK, 8'h04);
      #1;
      chk(16'(irq), 16'h1);
      rd(rsi_pkg::OFS_EVT_STATUS, d);
      chk(16'({d, 7'h0, irq}), 16'h3f00);
      rd(rsi_pkg::OFS_EVT_STATUS, d);
      chk(16'(d), 16'h00);
      // reset in mid-run returns every register to its reset value
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(16'(status_out), 16'h18);
      chk(16'({power_ctrl_status, irq_control}), 16'h0);
      chk(16'({option_out, port_a_direction}), 16'hffff);
      chk(16'({reg_rdata, 3'h0, periph_irq_flags}), 16'h0);
      chk(16'({pc_load, irq}), 16'h0);
      // pin reset and watchdog together: the pin reset wins
      @(posedge mclk);
      cause_v <= 5'h0c;
      @(posedge mclk);
      cause_v <= 5'h0;
      #1;
      chk(16'({pc_load, status_out}), 16'h118);
      report_and_stop();
   end
endmodule : reset_state_initializer_bench
`default_nettype wire
